// File: inc/itc_pkg.sv
package itc_pkg;
  // -----------------------------------------------------------------
  // Sizes and timing
  // -----------------------------------------------------------------
  localparam int NODES      = 17;
  localparam int CHANS      = 8;
  localparam int CHAIN_NODE = 16;
  localparam int EXT_BASE   = 12;
  localparam int EXT_MAX    = 4;
  localparam int RESP_MAX   = 8;
  localparam logic [6:0] TRAP_BASE  = 7'h10;
  localparam logic [6:0] TRAP_CHAIN = 7'h4C;

  // -----------------------------------------------------------------
  // Register fields
  // -----------------------------------------------------------------
  localparam int F_PRIO = 0;
  localparam int F_EN   = 4;
  localparam int F_REQ  = 5;
  localparam int F_XFER = 6;
  localparam int F_CH   = 7;
  localparam int C_CNT  = 0;
  localparam int C_BYTE = 8;
  localparam int C_INCS = 9;
  localparam int C_INCD = 10;
  localparam int C_CONT = 11;

  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam logic [3:0]  A_NODE_PAGE = 4'h0;
  localparam logic [3:0]  A_CHAN_PAGE = 4'h1;
  localparam logic [1:0]  W_CTRL      = 2'h0;
  localparam logic [1:0]  W_SRC       = 2'h1;
  localparam logic [1:0]  W_DST       = 2'h2;
  localparam logic [11:0] A_EDGE      = 12'h200;
  localparam logic [11:0] A_STAT      = 12'h204;
  localparam logic [11:0] A_CLR       = 12'h208;
  localparam logic [11:0] A_IEN       = 12'h20C;

  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_t;

  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_VECTOR = 2'b01,
    S_STEAL  = 2'b10
  } arb_state_t;

  function automatic logic [6:0] trap_of_node(input logic [4:0] n);
    if (n == 5'(CHAIN_NODE)) begin
      return TRAP_CHAIN;
    end
    return TRAP_BASE + {2'b00, n};
  endfunction

  function automatic logic [15:0] vec_of_trap(input logic [6:0] t);
    return {7'h00, t, 2'b00};
  endfunction
endpackage

// File: inc/edge_if.sv
`timescale 1ns/1ns
interface edge_if #(parameter int N = 4);
  logic [2*N-1:0] mode;
  logic [N-1:0]   hit;
  modport det (input mode, output hit);
  modport ctl (output mode, input hit);
endinterface

// File: core/pin_edge_detect.sv
`timescale 1ns/1ns
module pin_edge_detect #(
  parameter int N = 4
) (
  input wire logic         clk,
  input wire logic         rst_n,
  input wire logic [N-1:0] pin,
  edge_if.det              eif
);
  import itc_pkg::*;

  logic [N-1:0] meta_reg;
  logic [N-1:0] sync_reg;
  logic [N-1:0] prev_reg;
  logic [N-1:0] hit_reg;
  logic [N-1:0] hit_next;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  always_comb begin
    hit_next = '0;
    for (int i = 0; i < N; i++) begin
      if (sync_reg[i] && !prev_reg[i] && eif.mode[2*i]) begin
        hit_next[i] = 1'b1;
      end
      if (!sync_reg[i] && prev_reg[i] && eif.mode[2*i+1]) begin
        hit_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_reg <= '0;
    end else begin
      hit_reg <= hit_next;
    end
  end

  assign eif.hit = hit_reg;

  AST_EDGE_RISE_HITS: assert property (@(posedge clk) disable iff (!rst_n)
    (sync_reg[0] && !prev_reg[0] && eif.mode[0]) |=> hit_reg[0])
    else $error("Rising edge on input 0 was not reported.");
  AST_EDGE_OFF_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(eif.mode[1:0]) == EDGE_OFF) |-> !hit_reg[0])
    else $error("Input 0 reported an edge while detection is off.");
endmodule

// File: core/prioritized_interrupt_and_event_transfer.sv
`timescale 1ns/1ns
// -----------------------------------------------------------------
// -----------------------------------------------------------------
module prioritized_interrupt_and_event_transfer #(
  parameter int EXT_N = 4
) (
  input  wire logic                       MCLK,
  input  wire logic                       RST_N,
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [11:0]                PADDR,
  input  wire logic [31:0]                PWDATA,
  output wire logic [31:0]                PRDATA,
  output wire logic                       PREADY,
  output wire logic                       PSLVERR,
  input  wire logic [itc_pkg::NODES-1:0]  SRC_REQ,
  input  wire logic [EXT_N-1:0]           EXT_PIN,
  input  wire logic [3:0]                 CPU_LEVEL,
  input  wire logic                       TRAP_REQ,
  input  wire logic [6:0]                 TRAP_NUM,
  output wire logic                       VEC_REQ,
  output wire logic [15:0]                VEC_OFFSET,
  output wire logic [3:0]                 VEC_LEVEL,
  input  wire logic                       VEC_ACK,
  output wire logic                       STEAL_REQ,
  input  wire logic                       STEAL_GNT,
  output wire logic [15:0]                STEAL_SRC,
  output wire logic [15:0]                STEAL_DST,
  output wire logic                       STEAL_BYTE,
  output wire logic                       IRQ
);
  import itc_pkg::*;

  if (EXT_N < 1 || EXT_N > EXT_MAX) begin : g_bad_ext
    $error("EXT_N must lie between 1 and 4.");
  end

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  logic [3:0]       prio_reg [NODES];
  logic [2:0]       chsel_reg [NODES];
  logic [NODES-1:0] en_reg;
  logic [NODES-1:0] req_reg;
  logic [NODES-1:0] req_next;
  logic [NODES-1:0] xfer_reg;
  logic [NODES-1:0] set_req;
  logic [7:0]       cnt_reg [CHANS];
  logic [15:0]      src_reg [CHANS];
  logic [15:0]      dst_reg [CHANS];
  logic [CHANS-1:0] byte_reg;
  logic [CHANS-1:0] incs_reg;
  logic [CHANS-1:0] incd_reg;
  logic [CHANS-1:0] cont_reg;
  logic [CHANS-1:0] stat_reg;
  logic [CHANS-1:0] ien_reg;
  logic [2*EXT_N-1:0] edge_cfg_reg;
  arb_state_t       state_reg;
  logic [4:0]       cur_node_reg;
  logic [2:0]       cur_ch_reg;
  logic             trap_pend_reg;
  logic [6:0]       trap_num_reg;
  logic             vec_sw_reg;
  logic [15:0]      vec_ofs_reg;
  logic [3:0]       vec_lvl_reg;
  logic [31:0]      prdata_reg;
  logic             pslverr_reg;

  // -----------------------------------------------------------------
  // Register bus decode
  // -----------------------------------------------------------------
  logic        wr_en;
  logic        node_hit;
  logic        chan_hit;
  logic [4:0]  node_idx;
  logic [2:0]  chan_idx;
  logic [31:0] rd_data;
  logic        rd_err;

  assign wr_en    = PSEL && PENABLE && PWRITE;
  assign node_idx = PADDR[6:2];
  assign chan_idx = PADDR[6:4];
  assign node_hit = (PADDR[11:8] == A_NODE_PAGE) && (PADDR[1:0] == 2'b00)
                    && (PADDR[7:2] < 6'(NODES));
  assign chan_hit = (PADDR[11:8] == A_CHAN_PAGE) && (PADDR[1:0] == 2'b00)
                    && !PADDR[7] && (PADDR[3:2] != 2'b11);

  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (node_hit) begin
      rd_data[F_PRIO +: 4] = prio_reg[node_idx];
      rd_data[F_EN]        = en_reg[node_idx];
      rd_data[F_REQ]       = req_reg[node_idx];
      rd_data[F_XFER]      = xfer_reg[node_idx];
      rd_data[F_CH +: 3]   = chsel_reg[node_idx];
    end else if (chan_hit) begin
      if (PADDR[3:2] == W_CTRL) begin
        rd_data[C_CNT +: 8] = cnt_reg[chan_idx];
        rd_data[C_BYTE]     = byte_reg[chan_idx];
        rd_data[C_INCS]     = incs_reg[chan_idx];
        rd_data[C_INCD]     = incd_reg[chan_idx];
        rd_data[C_CONT]     = cont_reg[chan_idx];
      end else if (PADDR[3:2] == W_SRC) begin
        rd_data[15:0] = src_reg[chan_idx];
      end else begin
        rd_data[15:0] = dst_reg[chan_idx];
      end
    end else if (PADDR == A_EDGE) begin
      rd_data[2*EXT_N-1:0] = edge_cfg_reg;
    end else if (PADDR == A_STAT) begin
      rd_data[CHANS-1:0] = stat_reg;
    end else if (PADDR == A_IEN) begin
      rd_data[CHANS-1:0] = ien_reg;
    end else if (PADDR != A_CLR) begin
      rd_err = 1'b1;
    end
  end

  // Read data is captured in the setup cycle so that it leaves a flip-flop.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      prdata_reg  <= PWRITE ? 32'h0000_0000 : rd_data;
      pslverr_reg <= rd_err;
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = 1'b1;
  assign PSLVERR = pslverr_reg;

  // -----------------------------------------------------------------
  // External edge inputs
  // -----------------------------------------------------------------
  edge_if #(.N(EXT_N)) eif ();
  assign eif.mode = edge_cfg_reg;

  pin_edge_detect #(.N(EXT_N)) u_edge (
    .clk   (MCLK),
    .rst_n (RST_N),
    .pin   (EXT_PIN),
    .eif   (eif)
  );

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      edge_cfg_reg <= '0;
    end else if (wr_en && PADDR == A_EDGE) begin
      edge_cfg_reg <= PWDATA[2*EXT_N-1:0];
    end
  end

  // -----------------------------------------------------------------
  // Arbitration
  // -----------------------------------------------------------------
  logic       win_vld;
  logic [4:0] win_idx;
  logic [3:0] win_prio;
  logic       steal_done;
  logic       cnt_last;
  logic [7:0] cur_cnt;
  logic [15:0] cur_src;
  logic [15:0] step;

  always_comb begin
    win_vld  = 1'b0;
    win_idx  = '0;
    win_prio = '0;
    for (int i = 0; i < NODES; i++) begin
      if (req_reg[i] && en_reg[i] && prio_reg[i] > CPU_LEVEL
          && (!win_vld || prio_reg[i] > win_prio)) begin
        win_vld  = 1'b1;
        win_idx  = 5'(i);
        win_prio = prio_reg[i];
      end
    end
  end

  assign cur_cnt    = cnt_reg[cur_ch_reg];
  assign cur_src    = src_reg[cur_ch_reg];
  assign step       = byte_reg[cur_ch_reg] ? 16'h0001 : 16'h0002;
  assign steal_done = (state_reg == S_STEAL) && STEAL_GNT;
  assign cnt_last   = !cont_reg[cur_ch_reg] && (cur_cnt == 8'h01);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg    <= S_IDLE;
      cur_node_reg <= '0;
      cur_ch_reg   <= '0;
      vec_sw_reg   <= 1'b0;
      vec_ofs_reg  <= '0;
      vec_lvl_reg  <= '0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (trap_pend_reg) begin
            vec_ofs_reg <= vec_of_trap(trap_num_reg);
            vec_sw_reg  <= 1'b1;
            vec_lvl_reg <= CPU_LEVEL;
            state_reg   <= S_VECTOR;
          end else if (win_vld) begin
            cur_node_reg <= win_idx;
            cur_ch_reg   <= chsel_reg[win_idx];
            if (xfer_reg[win_idx] && cnt_reg[chsel_reg[win_idx]] != 8'h00) begin
              state_reg <= S_STEAL;
            end else begin
              vec_ofs_reg <= vec_of_trap(trap_of_node(win_idx));
              vec_sw_reg  <= 1'b0;
              vec_lvl_reg <= win_prio;
              state_reg   <= S_VECTOR;
            end
          end
        end
        S_VECTOR: begin
          if (VEC_ACK) begin
            state_reg <= S_IDLE;
          end
        end
        S_STEAL: begin
          if (STEAL_GNT) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // A second trap before the first is vectored overwrites it; the core issues one at a time.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      trap_pend_reg <= 1'b0;
      trap_num_reg  <= '0;
    end else if (TRAP_REQ) begin
      trap_pend_reg <= 1'b1;
      trap_num_reg  <= TRAP_NUM;
    end else if (state_reg == S_IDLE) begin
      trap_pend_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Node control
  // -----------------------------------------------------------------
  always_comb begin
    set_req = SRC_REQ;
    for (int i = 0; i < EXT_N; i++) begin
      set_req[EXT_BASE+i] = set_req[EXT_BASE+i] | eif.hit[i];
    end
    set_req[CHAIN_NODE] = set_req[CHAIN_NODE] | (steal_done && cnt_last);
  end

  // Hardware sets win over a clear in the same cycle so no event is lost.
  always_comb begin
    for (int i = 0; i < NODES; i++) begin
      req_next[i] = req_reg[i];
      if (wr_en && node_hit && node_idx == 5'(i)) begin
        req_next[i] = PWDATA[F_REQ];
      end
      if (state_reg == S_VECTOR && VEC_ACK && !vec_sw_reg && cur_node_reg == 5'(i)) begin
        req_next[i] = 1'b0;
      end
      if (steal_done && !cnt_last && cur_node_reg == 5'(i)) begin
        req_next[i] = 1'b0;
      end
      if (set_req[i]) begin
        req_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      req_reg  <= '0;
      en_reg   <= '0;
      xfer_reg <= '0;
      for (int i = 0; i < NODES; i++) begin
        prio_reg[i]  <= '0;
        chsel_reg[i] <= '0;
      end
    end else begin
      req_reg <= req_next;
      if (wr_en && node_hit) begin
        prio_reg[node_idx]  <= PWDATA[F_PRIO +: 4];
        en_reg[node_idx]    <= PWDATA[F_EN];
        xfer_reg[node_idx]  <= PWDATA[F_XFER];
        chsel_reg[node_idx] <= PWDATA[F_CH +: 3];
      end
    end
  end

  // -----------------------------------------------------------------
  // Event transfer channels
  // -----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      byte_reg <= '0;
      incs_reg <= '0;
      incd_reg <= '0;
      cont_reg <= '0;
      for (int c = 0; c < CHANS; c++) begin
        cnt_reg[c] <= '0;
        src_reg[c] <= '0;
        dst_reg[c] <= '0;
      end
    end else if (steal_done) begin
      if (incs_reg[cur_ch_reg]) begin
        src_reg[cur_ch_reg] <= cur_src + step;
      end
      if (incd_reg[cur_ch_reg]) begin
        dst_reg[cur_ch_reg] <= dst_reg[cur_ch_reg] + step;
      end
      if (!cont_reg[cur_ch_reg]) begin
        cnt_reg[cur_ch_reg] <= cur_cnt - 8'h01;
      end
    end else if (wr_en && chan_hit) begin
      if (PADDR[3:2] == W_CTRL) begin
        cnt_reg[chan_idx]  <= PWDATA[C_CNT +: 8];
        byte_reg[chan_idx] <= PWDATA[C_BYTE];
        incs_reg[chan_idx] <= PWDATA[C_INCS];
        incd_reg[chan_idx] <= PWDATA[C_INCD];
        cont_reg[chan_idx] <= PWDATA[C_CONT];
      end else if (PADDR[3:2] == W_SRC) begin
        src_reg[chan_idx] <= PWDATA[15:0];
      end else begin
        dst_reg[chan_idx] <= PWDATA[15:0];
      end
    end
  end

  assign VEC_REQ    = (state_reg == S_VECTOR);
  assign VEC_OFFSET = vec_ofs_reg;
  assign VEC_LEVEL  = vec_lvl_reg;
  assign STEAL_REQ  = (state_reg == S_STEAL);
  assign STEAL_SRC  = cur_src;
  assign STEAL_DST  = dst_reg[cur_ch_reg];
  assign STEAL_BYTE = byte_reg[cur_ch_reg];

  // -----------------------------------------------------------------
  // Channel completion interrupt
  // -----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_reg <= '0;
      ien_reg  <= '0;
    end else begin
      for (int c = 0; c < CHANS; c++) begin
        if (steal_done && cnt_last && cur_ch_reg == 3'(c)) begin
          stat_reg[c] <= 1'b1;
        end else if (wr_en && PADDR == A_CLR && PWDATA[c]) begin
          stat_reg[c] <= 1'b0;
        end
      end
      if (wr_en && PADDR == A_IEN) begin
        ien_reg <= PWDATA[CHANS-1:0];
      end
    end
  end

  assign IRQ = |(stat_reg & ien_reg);

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  AST_RESPONSE_TIME: assert property (
    (state_reg == S_IDLE && win_vld) |-> ##[1:8] (VEC_REQ || STEAL_REQ))
    else $error("Pending request not presented within 8 clocks.");
  AST_STEAL_ONE_CYCLE: assert property (
    (STEAL_REQ && STEAL_GNT) |=> !STEAL_REQ && !VEC_REQ)
    else $error("Transfer held the core longer than one granted cycle.");
  AST_COUNT_DOWN: assert property (
    (steal_done && !cont_reg[cur_ch_reg]) |=> cur_cnt == $past(cur_cnt) - 8'h01)
    else $error("Transfer count did not decrement.");
  AST_COUNT_HOLD: assert property (
    (steal_done && cont_reg[cur_ch_reg]) |=> cur_cnt == $past(cur_cnt))
    else $error("Continuous channel count changed.");
  AST_SRC_STEP: assert property (
    (steal_done && incs_reg[cur_ch_reg]) |=> cur_src == $past(cur_src) + $past(step))
    else $error("Source pointer did not step by the transfer size.");
  AST_ZERO_VECTORS: assert property (
    (state_reg == S_IDLE && !trap_pend_reg && win_vld && xfer_reg[win_idx]
     && cnt_reg[chsel_reg[win_idx]] == 8'h00) |=> VEC_REQ && !vec_sw_reg)
    else $error("Exhausted channel did not fall back to a vector.");
  AST_LEVEL_ABOVE_CORE: assert property (
    $rose(VEC_REQ) && !vec_sw_reg |-> VEC_LEVEL > $past(CPU_LEVEL))
    else $error("Vector raised at or below the core level.");
  AST_NODE_VECTOR: assert property (
    $rose(VEC_REQ) && !vec_sw_reg |-> VEC_OFFSET == {7'h00, trap_of_node(cur_node_reg), 2'b00})
    else $error("Node vector is not its trap number times four.");
  AST_TRAP_VECTOR: assert property (
    (TRAP_REQ && state_reg == S_IDLE && !trap_pend_reg && !win_vld) |=> ##1
    (VEC_REQ && VEC_OFFSET == {7'h00, $past(TRAP_NUM, 2), 2'b00}))
    else $error("Software trap not vectored to its number.");
  AST_CHAIN_END: assert property (
    (steal_done && cnt_last) |=> req_reg[CHAIN_NODE])
    else $error("Chain end node not raised when a count ran out.");
endmodule

// File: bench/cpu_core_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Core stand-in that accepts vectors and grants moves after a lag
// ---------------------------------------------------------------
module cpu_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] lag,
  input  wire logic       vec_req,
  input  wire logic       steal_req,
  output logic            vec_ack,
  output logic            steal_gnt
);
  logic [1:0] cnt_reg;

  // Each answer is a single pulse, so one request is never taken twice.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg   <= 2'h0;
      vec_ack   <= 1'b0;
      steal_gnt <= 1'b0;
    end else if (vec_ack || steal_gnt) begin
      vec_ack   <= 1'b0;
      steal_gnt <= 1'b0;
    end else if (vec_req || steal_req) begin
      if (cnt_reg == lag) begin
        cnt_reg   <= 2'h0;
        vec_ack   <= vec_req;
        steal_gnt <= !vec_req && steal_req;
      end else begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end
endmodule

// File: bench/prioritized_interrupt_and_event_transfer_tb.sv
`timescale 1ns/1ns
module prioritized_interrupt_and_event_transfer_tb;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [16:0] src_req;
  logic [3:0]  ext_pin, cpu_level, vec_level;
  logic [6:0]  trap_num;
  logic [1:0]  lag;
  logic        trap_req, vec_req, vec_ack, steal_req, steal_gnt, steal_byte, irq;
  logic [15:0] vec_offset, steal_src, steal_dst;
  int          error_cnt, tests_run;

  prioritized_interrupt_and_event_transfer i_dut (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SRC_REQ(src_req), .EXT_PIN(ext_pin), .CPU_LEVEL(cpu_level),
    .TRAP_REQ(trap_req), .TRAP_NUM(trap_num), .VEC_REQ(vec_req),
    .VEC_OFFSET(vec_offset), .VEC_LEVEL(vec_level), .VEC_ACK(vec_ack),
    .STEAL_REQ(steal_req), .STEAL_GNT(steal_gnt), .STEAL_SRC(steal_src),
    .STEAL_DST(steal_dst), .STEAL_BYTE(steal_byte), .IRQ(irq));

  cpu_core_model i_core (
    .clk(mclk), .rst_n(rst_n), .lag(lag), .vec_req(vec_req),
    .steal_req(steal_req), .vec_ack(vec_ack), .steal_gnt(steal_gnt));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  // One idle edge follows each transfer so no signal is driven twice at one edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
    chk(32'(rerr), 32'(err));
  endtask

  task pulse(input int n);
    src_req[n] <= 1'b1;
    @(posedge mclk);
    src_req <= 17'h0;
  endtask

  task vec(input logic [15:0] off, input logic [3:0] lv);
    int n;
    n = 0;
    while (vec_req !== 1'b1 && n < 8) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(vec_req), 32'h1);
    chk(32'(vec_offset), 32'(off));
    chk(32'(vec_level), 32'(lv));
    n = 0;
    while (vec_req !== 1'b0 && n < 10) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task steal(input logic [15:0] s, input logic [15:0] d, input logic b);
    int n;
    n = 0;
    while (steal_req !== 1'b1 && n < 8) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(steal_req), 32'h1);
    chk(32'(vec_req), 32'h0);
    chk({steal_src, steal_dst}, {s, d});
    chk(32'(steal_byte), 32'(b));
    n = 0;
    while (steal_req !== 1'b0 && n < 10) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task novec;
    repeat (10) begin
      @(posedge mclk);
      chk(32'(vec_req), 32'h0);
    end
  endtask

  task test_done;
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #100000;
    error_cnt++;
    $display("CHECK FAILED %0t: watchdog expired", $time);
    test_done;
  end

  initial begin
    {rst_n, psel, penable, pwrite, trap_req} = 5'h0;
    {paddr, pwdata, src_req, ext_pin, cpu_level, trap_num, lag} = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h300, 32'h0, 1'b1);
    wr(12'h000, 32'h15);
    pulse(0);
    vec(16'h0040, 4'h5);
    wr(12'h03C, 32'h31);
    vec(16'h007C, 4'h1);
    cpu_level <= 4'h3;
    wr(12'h008, 32'h33);
    wr(12'h004, 32'h33);
    novec;
    cpu_level <= 4'h0;
    vec(16'h0044, 4'h3);
    vec(16'h0048, 4'h3);
    trap_num <= 7'h2A;
    trap_req <= 1'b1;
    @(posedge mclk);
    trap_req <= 1'b0;
    vec(16'h00A8, 4'h0);
    lag <= 2'h3;
    wr(12'h040, 32'h17);
    wr(12'h010, 32'h56);
    wr(12'h100, 32'h602);
    wr(12'h104, 32'h1000);
    wr(12'h108, 32'h2000);
    pulse(4);
    steal(16'h1000, 16'h2000, 1'b0);
    rd(12'h100, 32'h601, 1'b0);
    pulse(4);
    steal(16'h1002, 16'h2002, 1'b0);
    vec(16'h0130, 4'h7);
    vec(16'h0050, 4'h6);
    rd(12'h204, 32'h1, 1'b0);
    wr(12'h20C, 32'h1);
    chk(32'(irq), 32'h1);
    wr(12'h208, 32'h1);
    chk(32'(irq), 32'h0);
    rd(12'h204, 32'h0, 1'b0);
    lag <= 2'h0;
    wr(12'h014, 32'hD6);
    wr(12'h110, 32'hB01);
    wr(12'h114, 32'h3000);
    wr(12'h118, 32'h4000);
    pulse(5);
    steal(16'h3000, 16'h4000, 1'b1);
    pulse(5);
    steal(16'h3001, 16'h4000, 1'b1);
    rd(12'h110, 32'hB01, 1'b0);
    wr(12'h178, 32'h5A5A);
    rd(12'h178, 32'h5A5A, 1'b0);
    wr(12'h030, 32'h12);
    for (int m = 1; m < 4; m++) begin
      wr(12'h200, 32'(m));
      ext_pin <= (m == 2) ? 4'h0 : 4'h1;
      repeat (2) @(posedge mclk);
      vec(16'h0070, 4'h2);
    end
    ext_pin <= 4'h0;
    repeat (2) @(posedge mclk);
    vec(16'h0070, 4'h2);
    wr(12'h200, 32'h0);
    ext_pin <= 4'h1;
    novec;
    test_done;
  end
endmodule
